/* File: logic/dsw_pkg.sv */
// Package of constants and types for the dual converter serial write control
package dsw_pkg;

  // Converter code and command word widths
  localparam int DATA_W = 10;
  localparam int WORD_W = 16;
  localparam logic [3:0] LAST_BIT = 4'hf;

  // Command word field positions
  localparam int CMD_SEL_POS = 14;
  localparam int CMD_MODE_POS = 12;
  localparam int CMD_DATA_POS = 2;
  localparam int CMD_TERM_POS = 0;

  // Operating mode codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_BOTH = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Power-down termination codes; zero is not a valid option
  localparam logic [1:0] TERM_NONE = 2'h0;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CHAN_A = 8'h04;
  localparam logic [7:0] OFF_CHAN_B = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values of the channel codes and counters
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Pin levels while the host is idle
  localparam logic [2:0] PINS_IDLE = 3'h4;

  // Frame states, Gray coded along idle, shift, done
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_SHIFT = 2'b01,
    FS_DONE = 2'b11
  } dsw_frame_e;

  // Serial link pins
  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } dsw_link_s;

  // Decoded command word
  typedef struct packed {
    logic sel_b;
    logic [1:0] mode;
    logic [9:0] code;
    logic [1:0] term;
  } dsw_cmd_s;

endpackage : dsw_pkg

/* File: logic/dsw_pin_sync.sv */
// Two-flop synchroniser bank for the serial link pins
`timescale 1ns/1ps
module dsw_pin_sync
  import dsw_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic meta_nxt;
      logic hold_r;
      logic hold_nxt;

      // First flop feeds only the second one
      always_comb begin
        meta_nxt = async_in[i];
        hold_nxt = meta_r;
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_r <= RST_VAL[i];
          hold_r <= RST_VAL[i];
        end else begin
          meta_r <= meta_nxt;
          hold_r <= hold_nxt;
        end
      end

      assign sync_out[i] = hold_r;
    end
  endgenerate

endmodule : dsw_pin_sync

/* File: logic/dsw_serial_dac_ctrl.sv */
// Serial write front end and update control of a dual 10-bit converter
//
// Overview of operation
// - Two independent channels A and B, each holding a 10-bit output code.
// - One 16-bit shift register holds select, mode, power-down and code fields.
// - Mode bits choose updating both channels together or one channel alone.
// - After reset both outputs stay zero until the first valid complete write.
// - Power-down entered with one of three termination options from the word.
// - Shifting enabled only while frame sync is low; its fall starts a frame.
// - One data bit sampled per serial clock falling edge; host sets it up first.
// - Sixteenth falling edge applies the command to outputs or power-down state.
// - Frame sync rising before the sixteenth edge discards the partial word.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dsw_serial_dac_ctrl
  import dsw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dsw_link_s link_pins,
  output logic [9:0] channel_a_output,
  output logic [9:0] channel_b_output,
  output logic power_down,
  output logic [1:0] pd_term,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  dsw_link_s pin_s;
  logic sclk_d_r, sclk_d_nxt, sync_d_r, sync_d_nxt;
  dsw_frame_e state_r, state_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic apply_r, apply_nxt, abort_r, abort_nxt;
  logic sclk_fall, frame_start;
  dsw_cmd_s cmd;
  logic [9:0] code_a_r, code_a_nxt, code_b_r, code_b_nxt;
  logic pd_r, pd_nxt, written_r, written_nxt;
  logic [1:0] term_r, term_nxt;
  logic [15:0] done_cnt_r, done_cnt_nxt, abort_cnt_r, abort_cnt_nxt;
  logic en_r, en_nxt, clr_r, clr_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic [31:0] wdat_r, wdat_nxt;
  logic [3:0] wstb_r, wstb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Pins come from the host's domain, so they pass two flops first
  dsw_pin_sync #(
    .W(3),
    .RST_VAL(PINS_IDLE)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(link_pins),
    .sync_out(pin_s)
  );

  // Edge finders on the synchronised serial clock and frame sync
  assign sclk_fall = sclk_d_r & ~pin_s.sclk;
  assign frame_start = sync_d_r & ~pin_s.sync_n;

  // Frame sequencer and shift register
  always_comb begin
    sclk_d_nxt = pin_s.sclk;
    sync_d_nxt = pin_s.sync_n;
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    apply_nxt = 1'b0;
    abort_nxt = 1'b0;
    case (state_r)
      FS_IDLE: begin
        // Disabled link ignores whole frames, never half of one
        if (frame_start && en_r) begin
          state_nxt = FS_SHIFT;
          cnt_nxt = 4'h0;
        end
      end
      FS_SHIFT: begin
        if (pin_s.sync_n) begin
          state_nxt = FS_IDLE;
          abort_nxt = 1'b1;
        end else if (sclk_fall) begin
          shift_nxt = {shift_r[14:0], pin_s.din};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == LAST_BIT) begin
            apply_nxt = 1'b1;
            state_nxt = FS_DONE;
          end
        end
      end
      FS_DONE: begin
        // Extra clocks after the sixteenth are ignored until sync rises
        if (pin_s.sync_n) begin
          state_nxt = FS_IDLE;
        end
      end
      default: state_nxt = FS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_r <= 1'b0;
      sync_d_r <= 1'b1;
      state_r <= FS_IDLE;
      shift_r <= 16'h0000;
      cnt_r <= 4'h0;
      apply_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      sync_d_r <= sync_d_nxt;
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      apply_r <= apply_nxt;
      abort_r <= abort_nxt;
    end
  end

  // Field extraction from the finished word
  always_comb begin
    cmd.sel_b = shift_r[CMD_SEL_POS];
    cmd.mode = shift_r[CMD_MODE_POS +: 2];
    cmd.code = shift_r[CMD_DATA_POS +: DATA_W];
    cmd.term = shift_r[CMD_TERM_POS +: 2];
  end

  // Channel codes, power-down state and frame counters
  always_comb begin
    code_a_nxt = code_a_r;
    code_b_nxt = code_b_r;
    pd_nxt = pd_r;
    term_nxt = term_r;
    written_nxt = written_r;
    done_cnt_nxt = clr_r ? CNT_RST : done_cnt_r;
    abort_cnt_nxt = clr_r ? CNT_RST : abort_cnt_r;
    if (apply_r) begin
      // Reserved mode or missing termination leaves codes and power-down state as they were; the frame still counts as done
      case (cmd.mode)
        MODE_SINGLE: begin
          if (cmd.sel_b) begin
            code_b_nxt = cmd.code;
          end else begin
            code_a_nxt = cmd.code;
          end
          pd_nxt = 1'b0;
          written_nxt = 1'b1;
        end
        MODE_BOTH: begin
          code_a_nxt = cmd.code;
          code_b_nxt = cmd.code;
          pd_nxt = 1'b0;
          written_nxt = 1'b1;
        end
        MODE_PDOWN: begin
          if (cmd.term != TERM_NONE) begin
            pd_nxt = 1'b1;
            term_nxt = cmd.term;
            written_nxt = 1'b1;
          end
        end
        default: pd_nxt = pd_r;
      endcase
      // A clear in the same cycle applies first, so the count restarts at one
      done_cnt_nxt = (clr_r ? CNT_RST : done_cnt_r) + CNT_ONE;
    end
    if (abort_r) begin
      abort_cnt_nxt = (clr_r ? CNT_RST : abort_cnt_r) + CNT_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_a_r <= CODE_RST;
      code_b_r <= CODE_RST;
      pd_r <= 1'b0;
      term_r <= TERM_NONE;
      written_r <= 1'b0;
      done_cnt_r <= CNT_RST;
      abort_cnt_r <= CNT_RST;
    end else begin
      code_a_r <= code_a_nxt;
      code_b_r <= code_b_nxt;
      pd_r <= pd_nxt;
      term_r <= term_nxt;
      written_r <= written_nxt;
      done_cnt_r <= done_cnt_nxt;
      abort_cnt_r <= abort_cnt_nxt;
    end
  end

  assign channel_a_output = code_a_r;
  assign channel_b_output = code_b_r;
  assign power_down = pd_r;
  assign pd_term = term_r;

  // Bus write path: address and data taken in either order
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    waddr_nxt = waddr_r;
    wdat_nxt = wdat_r;
    wstb_nxt = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    en_nxt = en_r;
    clr_nxt = 1'b0;
    if (awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdat_nxt = wdata;
      wstb_nxt = wstrb;
    end
    if (aw_hold_r && w_hold_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (waddr_r)
        OFF_CTRL: begin
          if (wstb_r[0]) begin
            en_nxt = wdat_r[CTRL_EN_BIT];
            clr_nxt = wdat_r[CTRL_CLR_BIT];
          end
        end
        // Read-only registers accept and drop the write
        OFF_STATUS, OFF_CHAN_A, OFF_CHAN_B, OFF_COUNT: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // One write under way at a time
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= 8'h00;
      wdat_r <= 32'h00000000;
      wstb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      en_r <= CTRL_EN_RST;
      clr_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      waddr_r <= waddr_nxt;
      wdat_r <= wdat_nxt;
      wstb_r <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      en_r <= en_nxt;
      clr_r <= clr_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // Bus read path, one read under way at a time
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (araddr)
        OFF_STATUS: rdata_nxt = {27'h0, state_r != FS_IDLE, written_r, term_r, pd_r};
        OFF_CHAN_A: rdata_nxt = {22'h0, code_a_r};
        OFF_CHAN_B: rdata_nxt = {22'h0, code_b_r};
        OFF_CTRL: rdata_nxt = {31'h0, en_r};
        OFF_COUNT: rdata_nxt = {abort_cnt_r, done_cnt_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Checks on frame handling and register answers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bit_count_a: assert property (state_r == FS_DONE |-> cnt_r == 4'h0)
    else $error("bit counter not at sixteen when word ends");
  shift_gate_a: assert property ($changed(shift_r) |-> $past(!pin_s.sync_n))
    else $error("shift while frame sync high");
  sample_bit_a: assert property (state_r == FS_SHIFT && !pin_s.sync_n && sclk_fall
    |=> shift_r[0] == $past(pin_s.din))
    else $error("wrong bit sampled");
  apply_last_a: assert property (apply_r |-> $past(cnt_r) == LAST_BIT && $past(sclk_fall))
    else $error("apply not on sixteenth edge");
  abort_keep_a: assert property (state_r == FS_SHIFT && pin_s.sync_n
    |=> !apply_r ##1 $stable(code_a_r) && $stable(code_b_r) && $stable(pd_r))
    else $error("aborted frame changed outputs");
  zero_until_a: assert property (!written_r |-> code_a_r == CODE_RST && code_b_r == CODE_RST)
    else $error("output not zero before first write");
  both_update_a: assert property (apply_r && cmd.mode == MODE_BOTH
    |=> code_a_r == $past(cmd.code) && code_b_r == $past(cmd.code) && !pd_r)
    else $error("both channels not updated");
  single_upd_a: assert property (apply_r && cmd.mode == MODE_SINGLE && !cmd.sel_b
    |=> code_a_r == $past(cmd.code) && $stable(code_b_r))
    else $error("single channel update wrong");
  pd_enter_a: assert property (apply_r && cmd.mode == MODE_PDOWN && cmd.term != TERM_NONE
    |=> pd_r && term_r == $past(cmd.term))
    else $error("power-down not entered");
  resp_hold_a: assert property (bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped");
  rdata_hold_a: assert property (rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped");

  frame_done_c: cover property (apply_r && cmd.mode == MODE_SINGLE);
  frame_abort_c: cover property (abort_r);
  both_write_c: cover property (apply_r && cmd.mode == MODE_BOTH);
  pdown_c: cover property (apply_r && cmd.mode == MODE_PDOWN && cmd.term != TERM_NONE);

endmodule : dsw_serial_dac_ctrl

/* File: verification/dsw_host_model.sv */
// Host model that writes command words over the three-wire serial link
`timescale 1ns/1ps
module dsw_host_model
  import dsw_pkg::*;
(
  input wire logic aclk,
  output dsw_link_s link
);
  // 80 ns half period of the serial clock at 8 ns per aclk
  localparam int HALF = 10;
  // Idle pins before the first frame; the serial clock stands still
  initial begin
    link = PINS_IDLE;
  end
  // Fewer than 16 bits aborts; more adds stray clocks after the word
  task automatic send(input logic [15:0] word, input int nbits);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    link.sync_n <= 1'b0;
    repeat (HALF) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      b = (i < 16) ? word[15 - i] : 1'b1;
      // Data moves while the clock is high, so a rising-edge sampler would fail
      link.sclk <= 1'b1;
      repeat (HALF / 2) @(posedge aclk);
      link.din <= b;
      repeat (HALF / 2) @(posedge aclk);
      link.sclk <= 1'b0;
      repeat (HALF) @(posedge aclk);
    end
    link.sync_n <= 1'b1;
    link.din <= ~b; // Released line must not keep the last bit
    repeat (HALF) @(posedge aclk);
  endtask : send
endmodule : dsw_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the dual converter serial write control
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import dsw_pkg::*;
  logic aclk, aresetn;
  dsw_link_s link;
  logic [9:0] out_a, out_b;
  logic pd;
  logic [1:0] term, bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  int err_count, n_compared, cycles;

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  dsw_serial_dac_ctrl i_dut (
    .aclk(aclk), .aresetn(aresetn), .link_pins(link),
    .channel_a_output(out_a), .channel_b_output(out_b),
    .power_down(pd), .pd_term(term),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  dsw_host_model i_host (
    .aclk(aclk),
    .link(link)
  );

  // Verdict and end of run
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("timeout");
      close_out();
    end
  end

  // Command word: spare, select, mode, code, termination
  function automatic logic [15:0] mk(input logic s, input logic [1:0] m,
                                     input logic [9:0] c, input logic [1:0] t);
    return {1'b0, s, m, c, t};
  endfunction : mk

  // Bus write; address and data released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  // Bus read, compared against the expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask : rd

  // Output codes and power state
  task automatic chk_out(input logic [9:0] ea, input logic [9:0] eb, input logic ep);
    `CHK(out_a, ea)
    `CHK(out_b, eb)
    `CHK(pd, ep)
  endtask : chk_out

  // Reset values; a reserved-mode frame is not a valid first write
  task automatic t_reset;
    chk_out(10'h000, 10'h000, 1'b0);
    rd(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    rd(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    rd(OFF_COUNT, 32'h0000_0000, RESP_OKAY);
    i_host.send(mk(1'b0, MODE_RSVD, 10'h3ff, 2'h1), 16);
    chk_out(10'h000, 10'h000, 1'b0);
    rd(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    $display("test reset done");
  endtask : t_reset

  // Single-channel and both-channel updates
  task automatic t_update;
    i_host.send(mk(1'b0, MODE_SINGLE, 10'h155, 2'h0), 16);
    chk_out(10'h155, 10'h000, 1'b0);
    i_host.send(mk(1'b1, MODE_SINGLE, 10'h2aa, 2'h0), 16);
    chk_out(10'h155, 10'h2aa, 1'b0);
    rd(OFF_CHAN_B, 32'h0000_02aa, RESP_OKAY);
    i_host.send(mk(1'b1, MODE_BOTH, 10'h3c3, 2'h0), 16);
    chk_out(10'h3c3, 10'h3c3, 1'b0);
    $display("test update done");
  endtask : t_update

  // Frames cut after 15 and 1 bits, then stray clocks past the 16th
  task automatic t_abort;
    i_host.send(mk(1'b0, MODE_SINGLE, 10'h000, 2'h0), 15);
    chk_out(10'h3c3, 10'h3c3, 1'b0);
    i_host.send(mk(1'b0, MODE_SINGLE, 10'h000, 2'h0), 1);
    chk_out(10'h3c3, 10'h3c3, 1'b0);
    i_host.send(mk(1'b0, MODE_SINGLE, 10'h001, 2'h0), 18);
    chk_out(10'h001, 10'h3c3, 1'b0);
    $display("test abort done");
  endtask : t_abort

  // Every termination option, an invalid one, and leaving power-down
  task automatic t_pdown;
    for (int t = 1; t < 4; t++) begin
      i_host.send(mk(1'b0, MODE_PDOWN, 10'h000, t[1:0]), 16);
      chk_out(10'h001, 10'h3c3, 1'b1);
      `CHK(term, t[1:0])
    end
    i_host.send(mk(1'b0, MODE_PDOWN, 10'h000, TERM_NONE), 16);
    `CHK(term, 2'h3)
    rd(OFF_STATUS, 32'h0000_000f, RESP_OKAY);
    i_host.send(mk(1'b0, MODE_SINGLE, 10'h100, 2'h0), 16);
    chk_out(10'h100, 10'h3c3, 1'b0);
    $display("test pdown done");
  endtask : t_pdown

  // Link disabled frames ignored; counters read and cleared
  task automatic t_enable;
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    i_host.send(mk(1'b1, MODE_SINGLE, 10'h0aa, 2'h0), 16);
    chk_out(10'h100, 10'h3c3, 1'b0);
    wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    rd(OFF_COUNT, 32'h0002_000a, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
    rd(OFF_COUNT, 32'h0000_0000, RESP_OKAY);
    rd(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    $display("test enable done");
  endtask : t_enable

  // Unmapped address and write to a read-only register
  task automatic t_bus;
    rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    wr(8'h14, 32'h0000_0001, RESP_SLVERR);
    wr(OFF_CHAN_A, 32'h0000_0000, RESP_OKAY);
    rd(OFF_CHAN_A, 32'h0000_0100, RESP_OKAY);
    // Control write with its low byte lane off is dropped
    wstrb <= 4'h0;
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    $display("test bus done");
  endtask : t_bus

  // Reset in mid-run; outputs stay zero until the next valid write
  task automatic t_midrst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_out(10'h000, 10'h000, 1'b0);
    rd(OFF_COUNT, 32'h0000_0000, RESP_OKAY);
    i_host.send(mk(1'b1, MODE_SINGLE, 10'h0f0, 2'h0), 16);
    chk_out(10'h000, 10'h0f0, 1'b0);
    rd(OFF_STATUS, 32'h0000_0008, RESP_OKAY);
    $display("test midrst done");
  endtask : t_midrst

  // Main sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_update();
    t_abort();
    t_pdown();
    t_enable();
    t_bus();
    t_midrst();
    close_out();
  end
endmodule : tb_top
